/* File: inc/rtow_cfg.svh */
// Constants for the reload timer with one-shot and waveform modes
`ifndef RTOW_CFG_SVH
`define RTOW_CFG_SVH
`define RTOW_A_CTRL 3'h0
`define RTOW_A_OSCTL 3'h1
`define RTOW_A_IOC 3'h2
`define RTOW_A_MODE 3'h3
`define RTOW_A_PRE 3'h4
`define RTOW_A_SEC 3'h5
`define RTOW_A_PRI 3'h6
`define RTOW_A_PORT 3'h7
`define RTOW_B_START 0
`define RTOW_B_CSTF 1
`define RTOW_B_FSTOP 2
`define RTOW_B_OSST 0
`define RTOW_B_OSSP 1
`define RTOW_B_OSSTF 2
`define RTOW_B_TRGEN 0
`define RTOW_B_PDIR 0
`define RTOW_B_PDAT 1
`define RTOW_RST_BYTE 8'hFF
`define RTOW_ZERO 8'h00
`define RTOW_SRC_DIV 4'h3
`endif

/* File: inc/rtow_pkg.sv */
// Types for the reload timer with one-shot and waveform modes
package rtow_pkg;
  typedef enum logic [1:0] {
    RTOW_TIMER,
    RTOW_WAVE,
    RTOW_ONESHOT,
    RTOW_WAIT_ONESHOT
  } rtow_mode_t;
  typedef enum logic [1:0] {
    RTOW_IDLE,
    RTOW_PRIMARY,
    RTOW_SECONDARY
  } rtow_phase_t;
endpackage : rtow_pkg

/* File: logic/rtow_timer.sv */
// Prescaler plus reload counter timer with one-shot and waveform modes
`timescale 1ns/1ps
`default_nettype none
`include "rtow_cfg.svh"
module rtow_timer
  import rtow_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic external_trigger_pin,
  output logic waveform_output_pin,
  output logic underflow_pulse
);
  // Count source: one enable pulse every RTOW_SRC_DIV+1 clocks
  logic [3:0] div_q, div_d;
  logic src_en;
  assign src_en = (div_q == `RTOW_SRC_DIV);
  always_comb begin
    div_d = src_en ? 4'h0 : 4'(div_q + 4'h1);
  end

  logic start_q, start_d, cstf_q, cstf_d, sync1_q, sync1_d;
  logic fstop_q, fstop_d;
  logic osreq_q, osreq_d, osstop_q, osstop_d, ossync_q, ossync_d, osstf_q, osstf_d;
  logic trgen_q, trgen_d, pdir_q, pdir_d, pdat_q, pdat_d;
  logic [1:0] mode_q, mode_d;
  logic [7:0] pre_q, pre_d, sec_q, sec_d, pri_q, pri_d;
  logic [7:0] pcnt_q, pcnt_d, cnt_q, cnt_d;
  rtow_phase_t ph_q, ph_d;
  logic wave_q, wave_d, uf_q, uf_d;
  logic [7:0] rdata_d;
  logic trig_q, trig_d;
  rtow_mode_t mode;
  logic oneshot_mode, pre_uf, cnt_uf, run, stop_reload;

  assign mode = rtow_mode_t'(mode_q);
  assign oneshot_mode = (mode == RTOW_ONESHOT) || (mode == RTOW_WAIT_ONESHOT);
  // Counting runs only once the status flag has followed the start bit
  // A pending one-shot stop freezes the reloaded count until status falls
  assign run = cstf_q && !fstop_q && (!oneshot_mode || (osstf_q && !osstop_q));
  assign pre_uf = run && src_en && (pcnt_q == `RTOW_ZERO);
  assign cnt_uf = pre_uf && (cnt_q == `RTOW_ZERO);

  always_comb begin
    start_d = start_q;
    fstop_d = fstop_q;
    mode_d = mode_q;
    trgen_d = trgen_q;
    pdir_d = pdir_q;
    pdat_d = pdat_q;
    pre_d = pre_q;
    sec_d = sec_q;
    pri_d = pri_q;
    osreq_d = osreq_q;
    osstop_d = osstop_q;
    stop_reload = 1'b0;
    if (wr) begin
      case (addr)
        `RTOW_A_CTRL: begin
          start_d = wdata[`RTOW_B_START];
          fstop_d = wdata[`RTOW_B_FSTOP];
          if (!wdata[`RTOW_B_START] && oneshot_mode) begin
            stop_reload = 1'b1;
          end
        end
        `RTOW_A_OSCTL: begin
          // Stop wins when start and stop bits are written together; either result is legal
          if (wdata[`RTOW_B_OSST]) begin
            osreq_d = 1'b1;
            osstop_d = 1'b0;
          end
          if (wdata[`RTOW_B_OSSP]) begin
            osstop_d = 1'b1;
            osreq_d = 1'b0;
            stop_reload = 1'b1;
          end
        end
        `RTOW_A_IOC: trgen_d = wdata[`RTOW_B_TRGEN];
        `RTOW_A_MODE: mode_d = wdata[1:0];
        `RTOW_A_PRE: pre_d = wdata;
        `RTOW_A_SEC: sec_d = wdata;
        `RTOW_A_PRI: pri_d = wdata;
        `RTOW_A_PORT: begin
          pdir_d = wdata[`RTOW_B_PDIR];
          pdat_d = wdata[`RTOW_B_PDAT];
        end
        default: begin
        end
      endcase
    end
    if (trig_q && trgen_q && oneshot_mode && !osstf_q) begin
      osreq_d = 1'b1;
    end
    // Forced stop in waveform mode restores the prescaler and primary period registers
    if (fstop_d && mode == RTOW_WAVE) begin
      pre_d = `RTOW_RST_BYTE;
      pri_d = `RTOW_RST_BYTE;
    end
  end

  // Status flags follow requests through a two-stage source-cycle sync
  always_comb begin
    sync1_d = sync1_q;
    cstf_d = cstf_q;
    ossync_d = ossync_q;
    osstf_d = osstf_q;
    if (src_en) begin
      sync1_d = start_q;
      cstf_d = sync1_q;
      ossync_d = osreq_q ? 1'b1 : (osstop_q ? 1'b0 : osstf_q);
      osstf_d = ossync_q;
    end
    if (fstop_q) begin
      sync1_d = 1'b0;
      cstf_d = 1'b0;
      ossync_d = 1'b0;
      osstf_d = 1'b0;
    end
  end

  // Counter, phase and waveform
  always_comb begin
    pcnt_d = pcnt_q;
    cnt_d = cnt_q;
    ph_d = ph_q;
    wave_d = wave_q;
    uf_d = 1'b0;
    if (fstop_q || stop_reload || !cstf_q) begin
      if (fstop_q || stop_reload || !start_q) begin
        pcnt_d = pre_q;
        cnt_d = pri_q;
        ph_d = RTOW_PRIMARY;
        wave_d = 1'b0;
      end
    end else if (run && src_en) begin
      pcnt_d = pre_uf ? pre_q : 8'(pcnt_q - 8'h01);
      if (pre_uf) begin
        cnt_d = 8'(cnt_q - 8'h01);
      end
      if (cnt_uf) begin
        uf_d = 1'b1;
        case (mode)
          RTOW_WAVE: begin
            ph_d = (ph_q == RTOW_PRIMARY) ? RTOW_SECONDARY : RTOW_PRIMARY;
            cnt_d = (ph_q == RTOW_PRIMARY) ? sec_q : pri_q;
            wave_d = (ph_q == RTOW_PRIMARY);
          end
          RTOW_WAIT_ONESHOT: begin
            ph_d = (ph_q == RTOW_PRIMARY) ? RTOW_SECONDARY : RTOW_PRIMARY;
            cnt_d = (ph_q == RTOW_PRIMARY) ? sec_q : pri_q;
            wave_d = (ph_q == RTOW_PRIMARY);
          end
          default: begin
            cnt_d = pri_q;
            wave_d = (mode == RTOW_ONESHOT);
          end
        endcase
      end
    end
  end

  logic os_done;
  assign os_done = oneshot_mode && cnt_uf &&
    ((mode == RTOW_ONESHOT) || (ph_q == RTOW_SECONDARY));
  logic osreq_n, osstop_n;
  always_comb begin
    osreq_n = osreq_d;
    osstop_n = osstop_d;
    if (src_en && ossync_q) begin
      osreq_n = 1'b0;
    end
    if (os_done) begin
      osstop_n = 1'b1;
      osreq_n = 1'b0;
    end
    if (src_en && !ossync_q && osstop_q && !osreq_q) begin
      osstop_n = 1'b0;
    end
  end

  // Reads take each byte separately; no latch ties prescaler to counter
  always_comb begin
    trig_d = external_trigger_pin;
    rdata_d = 8'h00;
    if (rd) begin
      case (addr)
        `RTOW_A_CTRL: begin
          rdata_d[`RTOW_B_START] = start_q;
          rdata_d[`RTOW_B_CSTF] = cstf_q;
          rdata_d[`RTOW_B_FSTOP] = fstop_q;
        end
        `RTOW_A_OSCTL: rdata_d[`RTOW_B_OSSTF] = osstf_q;
        `RTOW_A_IOC: rdata_d[`RTOW_B_TRGEN] = trgen_q;
        `RTOW_A_MODE: rdata_d[1:0] = mode_q;
        `RTOW_A_PRE: rdata_d = pcnt_q;
        `RTOW_A_SEC: rdata_d = sec_q;
        `RTOW_A_PRI: rdata_d = cnt_q;
        `RTOW_A_PORT: begin
          rdata_d[`RTOW_B_PDIR] = pdir_q;
          rdata_d[`RTOW_B_PDAT] = pdir_q ? pdat_q : wave_q;
        end
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 4'h0;
      start_q <= 1'b0;
      cstf_q <= 1'b0;
      sync1_q <= 1'b0;
      fstop_q <= 1'b0;
      osreq_q <= 1'b0;
      osstop_q <= 1'b0;
      ossync_q <= 1'b0;
      osstf_q <= 1'b0;
      trgen_q <= 1'b0;
      pdir_q <= 1'b0;
      pdat_q <= 1'b0;
      mode_q <= 2'h0;
      pre_q <= `RTOW_RST_BYTE;
      sec_q <= `RTOW_RST_BYTE;
      pri_q <= `RTOW_RST_BYTE;
      pcnt_q <= `RTOW_RST_BYTE;
      cnt_q <= `RTOW_RST_BYTE;
      ph_q <= RTOW_PRIMARY;
      wave_q <= 1'b0;
      uf_q <= 1'b0;
      rdata <= 8'h00;
      trig_q <= 1'b0;
    end else begin
      div_q <= div_d;
      start_q <= start_d;
      cstf_q <= cstf_d;
      sync1_q <= sync1_d;
      fstop_q <= fstop_d;
      osreq_q <= osreq_n;
      osstop_q <= osstop_n;
      ossync_q <= ossync_d;
      osstf_q <= osstf_d;
      trgen_q <= trgen_d;
      pdir_q <= pdir_d;
      pdat_q <= pdat_d;
      mode_q <= mode_d;
      pre_q <= pre_d;
      sec_q <= sec_d;
      pri_q <= pri_d;
      pcnt_q <= pcnt_d;
      cnt_q <= cnt_d;
      ph_q <= ph_d;
      wave_q <= wave_d;
      uf_q <= uf_d;
      rdata <= rdata_d;
      trig_q <= trig_d;
    end
  end

  assign waveform_output_pin = wave_q;
  assign underflow_pulse = uf_q;

  a_reset_stopped: assert property (@(posedge clock) disable iff (!arst_n)
    !start_q && !sync1_q && !cstf_q |=> !run) else $error("timer runs without start bit");
  a_start_lag: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(start_q) && !fstop_q |-> !cstf_q [*2]) else $error("status rose too early");
  a_start_bound: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(start_q) && !fstop_q ##1 (start_q && !fstop_q && !wr) [*8] |-> cstf_q)
    else $error("status did not rise in time");
  a_stop_lag: assert property (@(posedge clock) disable iff (!arst_n)
    $fell(start_q) && cstf_q && !fstop_q |=> cstf_q || fstop_q)
    else $error("status fell at once");
  a_fstop_now: assert property (@(posedge clock) disable iff (!arst_n)
    fstop_q |-> !run ##1 !cstf_q) else $error("forced stop did not halt");
  a_cnt_change: assert property (@(posedge clock) disable iff (!arst_n)
    run && !src_en && !stop_reload |=> $stable(cnt_q)) else $error("count moved off source");
  a_wave_reset: assert property (@(posedge clock) disable iff (!arst_n)
    fstop_q && mode == RTOW_WAVE |-> pri_q == `RTOW_RST_BYTE) else $error("period kept");
  a_os_reload: assert property (@(posedge clock) disable iff (!arst_n)
    stop_reload && !fstop_q |=> cnt_q == $past(pri_q)) else $error("no reload on stop");
  a_port_read: assert property (@(posedge clock) disable iff (!arst_n)
    rd && addr == `RTOW_A_PORT && !pdir_q |=> rdata[`RTOW_B_PDAT] == $past(wave_q))
    else $error("port read wrong");
  a_os_status: assert property (@(posedge clock) disable iff (!arst_n)
    wr && addr == `RTOW_A_OSCTL && wdata[`RTOW_B_OSST] && !osstf_q && !ossync_q && !fstop_q
    |=> !osstf_q)
    else $error("oneshot status too early");
endmodule : rtow_timer
`default_nettype wire

/* File: test/tb_reload_timer_oneshot_waveform.sv */
// Self-checking bench for the reload timer with one-shot and waveform modes
`timescale 1ns/1ps
`default_nettype none
`include "rtow_cfg.svh"
module tb_reload_timer_oneshot_waveform;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic trig = 1'b0;
  logic [7:0] rdata;
  logic wave;
  logic unf;
  logic rd_d = 1'b0;
  logic [15:0] exp_q[$];
  logic [7:0] v;
  logic [7:0] p;
  logic [7:0] n;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int seed = 32'h0C99FDD2;
  int t;

  always #5 clock = ~clock;

  rtow_timer uut (.clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .external_trigger_pin(trig), .waveform_output_pin(wave),
    .underflow_pulse(unf));

  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic final_report;
    $display("mismatches %0d, comparisons %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wreg

  // Mask rides in the upper byte; a zero mask only captures the value
  task automatic rreg(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back({m, e});
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    v = rdata;
  endtask : rreg

  // Clocks from one underflow pulse to the next; 500 means none came
  task automatic gap(output int g);
    int k;
    for (k = 0; k < 500 && unf !== 1'b1; k++) @(posedge clock);
    @(posedge clock);
    for (g = 1; g < 500 && unf !== 1'b1; g++) @(posedge clock);
  endtask : gap

  task automatic settle;
    repeat (12) @(posedge clock);
  endtask : settle

  always @(posedge clock) rd_d <= rd;

  // Read data stands only in the cycle after the strobe
  always @(negedge clock) begin
    logic [15:0] x;
    if (rd_d && exp_q.size() > 0) begin
      x = exp_q.pop_front();
      if (x[15:8] != 8'h00) check((rdata & x[15:8]) === x[7:0], "register read");
    end
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      check(1'b0, "run did not finish");
      final_report();
    end
  end

  initial begin
    repeat (10) @(posedge clock);
    check(rdata === 8'h00 && wave === 1'b0 && unf === 1'b0, "outputs in reset");
    arst_n <= 1'b1;
    rreg(`RTOW_A_CTRL, 8'h02, 8'h00);
    rreg(`RTOW_A_PRI, 8'hFF, 8'hFF);
    repeat (40) @(posedge clock);
    rreg(`RTOW_A_PRI, 8'hFF, 8'hFF);
    rreg(`RTOW_A_PRE, 8'hFF, 8'hFF);
    rreg(`RTOW_A_SEC, 8'hFF, 8'hFF);
    // Timer mode with small random divisors keeps the run short
    p = {6'h00, 2'($random(seed))};
    n = {6'h00, 2'($random(seed))} + 8'h01;
    wreg(`RTOW_A_MODE, 8'h00);
    wreg(`RTOW_A_PRE, p);
    wreg(`RTOW_A_PRI, n);
    wreg(`RTOW_A_CTRL, 8'h01);
    rreg(`RTOW_A_CTRL, 8'h02, 8'h00);
    settle();
    settle();
    rreg(`RTOW_A_CTRL, 8'h02, 8'h02);
    gap(t);
    gap(t);
    check(t == 4 * (p + 1) * (n + 1), "underflow spacing");
    wreg(`RTOW_A_CTRL, 8'h00);
    rreg(`RTOW_A_CTRL, 8'h02, 8'h02);
    settle();
    rreg(`RTOW_A_CTRL, 8'h02, 8'h00);
    gap(t);
    check(t == 500, "count after stop");
    // Waveform mode halted by the forced stop
    wreg(`RTOW_A_MODE, 8'h01);
    wreg(`RTOW_A_PRE, 8'h00);
    wreg(`RTOW_A_SEC, 8'h02);
    wreg(`RTOW_A_PRI, 8'h02);
    wreg(`RTOW_A_CTRL, 8'h01);
    gap(t);
    check(t < 500, "waveform running");
    wreg(`RTOW_A_CTRL, 8'h05);
    rreg(`RTOW_A_PRE, 8'hFF, 8'hFF);
    rreg(`RTOW_A_PRI, 8'hFF, 8'hFF);
    gap(t);
    check(t == 500, "count after forced stop");
    wreg(`RTOW_A_CTRL, 8'h00);
    settle();
    // One-shot stop reloads the counter
    wreg(`RTOW_A_MODE, 8'h02);
    wreg(`RTOW_A_PRE, 8'h00);
    wreg(`RTOW_A_PRI, 8'h40);
    wreg(`RTOW_A_CTRL, 8'h01);
    settle();
    wreg(`RTOW_A_OSCTL, 8'h01);
    settle();
    rreg(`RTOW_A_OSCTL, 8'h04, 8'h04);
    repeat (20) @(posedge clock);
    rreg(`RTOW_A_PRI, 8'h00, 8'h00);
    wreg(`RTOW_A_OSCTL, 8'h02);
    rreg(`RTOW_A_OSCTL, 8'h04, 8'h04);
    settle();
    rreg(`RTOW_A_OSCTL, 8'h04, 8'h00);
    rreg(`RTOW_A_PRI, 8'hFF, 8'h40);
    wreg(`RTOW_A_CTRL, 8'h00);
    settle();
    // Wait one-shot fired by the trigger pin
    wreg(`RTOW_A_MODE, 8'h03);
    wreg(`RTOW_A_IOC, 8'h01);
    wreg(`RTOW_A_PORT, 8'h00);
    wreg(`RTOW_A_SEC, 8'h03);
    wreg(`RTOW_A_PRI, 8'h03);
    wreg(`RTOW_A_CTRL, 8'h01);
    settle();
    trig <= 1'b1;
    repeat (2) @(posedge clock);
    trig <= 1'b0;
    for (t = 0; t < 200 && wave !== 1'b1; t++) @(posedge clock);
    check(wave === 1'b1, "one-shot output");
    rreg(`RTOW_A_PORT, 8'h02, 8'h02);
    final_report();
  end
endmodule : tb_reload_timer_oneshot_waveform
`default_nettype wire
